// [rtl/scc_defines.svh]
// Register offsets, field positions, reset values and timing counts of the clock controller
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

`define SCC_ADDR_CTRL      8'h00
`define SCC_ADDR_GATE      8'h04
`define SCC_ADDR_STATUS    8'h08
`define SCC_ADDR_ISTAT     8'h0C
`define SCC_ADDR_IMASK     8'h10
`define SCC_ADDR_CCO       8'h14

`define SCC_CTRL_SRC_LSB   0
`define SCC_CTRL_DIV_LSB   2
`define SCC_CTRL_RTC_LSB   5
`define SCC_CTRL_CFM_BIT   7
`define SCC_CTRL_LP_LSB    8

`define SCC_GATE_CORE_BIT  0
`define SCC_GATE_MEM_BIT   1
`define SCC_GATE_PER_LSB   2
`define SCC_GATE_LCD_BIT   10

`define SCC_IRQ_CFM_BIT    0
`define SCC_IRQ_SW_BIT     1

`define SCC_CCO_EN_BIT     3

`define SCC_CTRL_RST       10'h06D
`define SCC_GATE_RST       11'h7FF
`define SCC_CCO_RST        4'h0

`define SCC_CLK_PERIOD_NS  4
`define SCC_CFM_TIMEOUT_NS 2000
`define SCC_CFM_TIMEOUT_CYC (`SCC_CFM_TIMEOUT_NS / `SCC_CLK_PERIOD_NS)

`endif

// [rtl/scc_pkg.sv]
// Types shared by the clock controller modules
package scc_pkg;

  typedef enum logic [1:0] {
    SRC_EXT_FAST = 2'b00,
    SRC_INT_FAST = 2'b01,
    SRC_EXT_SLOW = 2'b10,
    SRC_INT_SLOW = 2'b11
  } scc_src_e;

  typedef enum logic [1:0] {
    SW_IDLE     = 2'b00,
    SW_WAIT_RDY = 2'b01,
    SW_WAIT_LOW = 2'b10
  } scc_sw_e;

  typedef enum logic [1:0] {
    LP_RUN         = 2'b00,
    LP_WAIT        = 2'b01,
    LP_ACTIVE_HALT = 2'b10,
    LP_HALT        = 2'b11
  } scc_lp_e;

endpackage

// [rtl/scc_sync.sv]
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ns
module scc_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ff1_r <= '0;
      ff2_r <= '0;
    end else begin
      ff1_r <= asyncIn;
      ff2_r <= ff1_r;
    end
  end

  assign syncOut = ff2_r;

endmodule

// [rtl/scc_divider.sv]
// Power-of-two prescaler counting edges of the selected oscillator level
`timescale 1ns/1ns
module scc_divider (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       srcLvl,
  input  wire logic [2:0] ratioLog2,
  input  wire logic       restart,
  output logic            clkOut
);

  logic       prevLvl_r;
  logic [7:0] cnt_r;
  logic       clkOut_r;

  wire        srcEdge = srcLvl ^ prevLvl_r;
  wire  [7:0] limit   = 8'((8'h01 << ratioLog2) - 8'h01);
  wire        atLimit = (cnt_r >= limit);

  // Toggle every 2^n source edges, so output period is 2^n source periods
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prevLvl_r <= 1'b0;
      cnt_r     <= 8'h00;
      clkOut_r  <= 1'b0;
    end else begin
      prevLvl_r <= srcLvl;
      if (restart) begin
        cnt_r    <= 8'h00;
        clkOut_r <= 1'b0;
      end else if (srcEdge) begin
        cnt_r    <= atLimit ? 8'h00 : 8'(cnt_r + 8'h01);
        clkOut_r <= atLimit ? ~clkOut_r : clkOut_r;
      end
    end
  end

  assign clkOut = clkOut_r;

endmodule

// [rtl/scc_clock_ctrl.sv]
// System clock controller: source switching, prescaler, gating, failure monitor, clock output
// Operation
// - The selected system clock is divided by a software-set power-of-two prescaler before distribution.
// - The system source can be changed at run time by register without glitches on the distributed clock.
// - Core, each peripheral and memory clocks have their own software gate.
// - The system multiplexer takes external fast, internal fast, external slow and internal slow sources.
// - A separate selector picks any of the four sources for the real-time clock and display clocks.
// - After reset the system runs from the internal fast oscillator divided by eight.
// - Software may change prescaler and source at any time after reset.
// - The clock failure monitor stays off until software enables it.
// - An enabled monitor that sees the external fast oscillator fail switches to internal fast by itself.
// - A configurable clock output pin shows a chosen internal clock.
// - Low-power modes stop clocks, with only the real-time clock and the clock output pin left running in active-halt.
`timescale 1ns/1ns
`include "scc_defines.svh"
module scc_clock_ctrl (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  oscIn,
  input  wire logic [3:0]  oscReady,
  input  wire logic        wakeup,
  output logic             coreClk,
  output logic             memClk,
  output logic      [7:0]  periphClk,
  output logic             rtcClk,
  output logic             lcdClk,
  output logic             ccoOut,
  output logic             irq,
  output scc_pkg::scc_src_e activeSrc,
  output logic             switchBusy
);
  import scc_pkg::*;

  localparam logic [9:0] CFM_LIMIT = 10'(`SCC_CFM_TIMEOUT_CYC - 1);

  function automatic logic selBit(input logic [3:0] vec, input logic [1:0] sel);
    selBit = vec[sel];
  endfunction

  // Synchronised oscillator levels and ready flags
  logic [3:0] oscLvl;
  logic [3:0] oscRdy;

  scc_sync #(
    .W (8)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .asyncIn  ({oscReady, oscIn}),
    .syncOut  ({oscRdy, oscLvl})
  );

  logic [9:0]  ctrl_r;
  logic [9:0]  ctrl_nxt;
  logic [10:0] gate_r;
  logic [1:0]  istat_r;
  logic [1:0]  istat_nxt;
  logic [1:0]  imask_r;
  logic [3:0]  cco_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  scc_src_e    activeSrc_r;
  scc_sw_e     swState_r;
  scc_sw_e     swState_nxt;
  logic        prevExt_r;
  logic [9:0]  cfmCnt_r;
  logic        coreClk_r;
  logic        memClk_r;
  logic [7:0]  periphClk_r;
  logic        rtcClk_r;
  logic        lcdClk_r;
  logic        ccoOut_r;
  logic        irq_r;
  logic        switchBusy_r;
  logic        divClk;

  // APB decode
  wire        apbSetup  = psel & ~penable;
  wire        apbAccess = psel & penable & pready_r;
  wire        wrAccess  = apbAccess & pwrite;
  wire        hitCtrl   = (paddr == `SCC_ADDR_CTRL);
  wire        hitGate   = (paddr == `SCC_ADDR_GATE);
  wire        hitStatus = (paddr == `SCC_ADDR_STATUS);
  wire        hitIstat  = (paddr == `SCC_ADDR_ISTAT);
  wire        hitImask  = (paddr == `SCC_ADDR_IMASK);
  wire        hitCco    = (paddr == `SCC_ADDR_CCO);
  wire        hitAny    = hitCtrl | hitGate | hitStatus | hitIstat | hitImask | hitCco;
  wire        wrCtrl    = wrAccess & hitCtrl;
  wire        wrGate    = wrAccess & hitGate;
  wire        wrIstat   = wrAccess & hitIstat;
  wire        wrImask   = wrAccess & hitImask;
  wire        wrCco     = wrAccess & hitCco;

  // Control fields
  wire  [1:0] reqSrc  = ctrl_r[`SCC_CTRL_SRC_LSB +: 2];
  wire  [2:0] divLog2 = ctrl_r[`SCC_CTRL_DIV_LSB +: 3];
  wire  [1:0] rtcSel  = ctrl_r[`SCC_CTRL_RTC_LSB +: 2];
  wire        cfmEn   = ctrl_r[`SCC_CTRL_CFM_BIT];
  wire  [1:0] lpMode  = ctrl_r[`SCC_CTRL_LP_LSB +: 2];

  wire [31:0] statusWord = {25'h0, oscRdy, switchBusy_r, activeSrc_r};
  wire [31:0] rdMux =
    hitCtrl   ? {22'h0, ctrl_r}  :
    hitGate   ? {21'h0, gate_r}  :
    hitStatus ? statusWord       :
    hitIstat  ? {30'h0, istat_r} :
    hitImask  ? {30'h0, imask_r} :
    hitCco    ? {28'h0, cco_r}   : 32'h0;

  // Clock failure monitor on the external fast oscillator
  wire        extToggle = oscLvl[0] ^ prevExt_r;
  wire        cfmWatch  = cfmEn & (activeSrc_r == SRC_EXT_FAST);
  wire        cfmStall  = ~extToggle & (cfmCnt_r >= CFM_LIMIT);
  wire        cfmFail   = cfmWatch & (cfmStall | ~oscRdy[0]);
  // Counter clears with the failure it flags at the limit; any synced edge or leaving the watch restarts it
  wire        cfmClear  = extToggle | ~cfmWatch | cfmFail;
  wire  [9:0] cfmCntInc = 10'(cfmCnt_r + 10'h001);

  // Source switch sequencing
  wire        reqDiffers = (reqSrc != activeSrc_r);
  // The old source keeps running until the requested one reports ready
  wire        reqReady   = selBit(oscRdy, reqSrc);

  // Change only while the divided clock is low, so no runt pulse reaches the gates
  wire        lowPhase   = ~divClk;
  wire        switchNow  = (swState_r == SW_WAIT_LOW) & reqDiffers & reqReady & lowPhase & ~cfmFail;

  always_comb begin
    swState_nxt = swState_r;
    case (swState_r)
      SW_IDLE: begin
        if (reqDiffers) begin
          swState_nxt = SW_WAIT_RDY;
        end
      end
      SW_WAIT_RDY: begin
        if (!reqDiffers) begin
          swState_nxt = SW_IDLE;
        end else if (reqReady) begin
          swState_nxt = SW_WAIT_LOW;
        end
      end
      SW_WAIT_LOW: begin
        if (!reqDiffers || !reqReady || switchNow) begin
          swState_nxt = SW_IDLE;
        end
      end
      default: begin
        swState_nxt = SW_IDLE;
      end
    endcase
    if (cfmFail) begin
      swState_nxt = SW_IDLE;
    end
  end

  // Control register: software writes, monitor forces internal fast, wakeup returns to run
  always_comb begin
    ctrl_nxt = wrCtrl ? pwdata[9:0] : ctrl_r;
    if (cfmFail) begin
      ctrl_nxt[`SCC_CTRL_SRC_LSB +: 2] = SRC_INT_FAST;
    end
    if (wakeup) begin
      ctrl_nxt[`SCC_CTRL_LP_LSB +: 2] = LP_RUN;
    end
  end

  // Sticky events, set wins over write-one-to-clear
  wire  [1:0] events   = {switchNow, cfmFail};
  wire  [1:0] clrMask  = wrIstat ? pwdata[1:0] : 2'h0;
  assign istat_nxt = (istat_r & ~clrMask) | events;

  // Prescaled system clock from the active source
  wire        sysLvl = selBit(oscLvl, activeSrc_r);
  scc_divider u_div (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .srcLvl    (sysLvl),
    .ratioLog2 (divLog2),
    .restart   (switchNow | cfmFail),
    .clkOut    (divClk)
  );

  // Low-power mode clock permissions
  wire        runCore = (lpMode == LP_RUN);
  wire        runPer  = (lpMode == LP_RUN) | (lpMode == LP_WAIT);
  wire        runRtc  = (lpMode != LP_HALT);
  wire        rtcLvl  = selBit(oscLvl, rtcSel);
  wire        coreEn  = gate_r[`SCC_GATE_CORE_BIT] & runCore;
  wire        memEn   = gate_r[`SCC_GATE_MEM_BIT] & runPer;
  wire  [7:0] perEn   = {8{runPer}} & gate_r[`SCC_GATE_PER_LSB +: 8];
  wire        lcdEn   = gate_r[`SCC_GATE_LCD_BIT] & runPer;
  wire        irqPend = |(istat_r & imask_r);

  // Clock output selection: 0 system, 1..4 oscillators, 5 real-time clock
  // Selection changes are not sequenced; the output register bounds the shortest pulse
  wire  [2:0] ccoSel  = cco_r[2:0];
  wire        ccoPick =
    (ccoSel == 3'h0) ? divClk :
    (ccoSel == 3'h5) ? rtcLvl :
    (ccoSel <= 3'h4) ? selBit(oscLvl, 2'(ccoSel - 3'h1)) : 1'b0;

  // Every setup gets exactly one access cycle, no wait states
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apbSetup;
      pslverr_r <= apbSetup & ~hitAny;
      prdata_r  <= (apbSetup & ~pwrite) ? rdMux : 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r  <= `SCC_CTRL_RST;
      gate_r  <= `SCC_GATE_RST;
      istat_r <= 2'h0;
      imask_r <= 2'h0;
      cco_r   <= `SCC_CCO_RST;
    end else begin
      ctrl_r  <= ctrl_nxt;
      gate_r  <= wrGate ? pwdata[10:0] : gate_r;
      istat_r <= istat_nxt;
      imask_r <= wrImask ? pwdata[1:0] : imask_r;
      cco_r   <= wrCco ? pwdata[3:0] : cco_r;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      activeSrc_r  <= SRC_INT_FAST;
      swState_r    <= SW_IDLE;
      switchBusy_r <= 1'b0;
    end else begin
      swState_r    <= swState_nxt;
      switchBusy_r <= (swState_nxt != SW_IDLE);
      if (cfmFail) begin
        activeSrc_r <= SRC_INT_FAST;
      end else if (switchNow) begin
        activeSrc_r <= scc_src_e'(reqSrc);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prevExt_r <= 1'b0;
      cfmCnt_r  <= 10'h000;
    end else begin
      prevExt_r <= oscLvl[0];
      cfmCnt_r  <= cfmClear ? 10'h000 : (cfmStall ? cfmCnt_r : cfmCntInc);
    end
  end

  // Registered gated clocks
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      coreClk_r   <= 1'b0;
      memClk_r    <= 1'b0;
      periphClk_r <= 8'h00;
      rtcClk_r    <= 1'b0;
      lcdClk_r    <= 1'b0;
      ccoOut_r    <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      coreClk_r   <= divClk & coreEn;
      memClk_r    <= divClk & memEn;
      periphClk_r <= {8{divClk}} & perEn;
      rtcClk_r    <= rtcLvl & runRtc;
      lcdClk_r    <= rtcLvl & lcdEn;
      ccoOut_r    <= ccoPick & cco_r[`SCC_CCO_EN_BIT];
      irq_r       <= irqPend;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign coreClk    = coreClk_r;
  assign memClk     = memClk_r;
  assign periphClk  = periphClk_r;
  assign rtcClk     = rtcClk_r;
  assign lcdClk     = lcdClk_r;
  assign ccoOut     = ccoOut_r;
  assign irq        = irq_r;
  assign activeSrc  = activeSrc_r;
  assign switchBusy = switchBusy_r;

endmodule

// [test/scc_osc_model.sv]
// Oscillator model: four free-running sources with ready flags
`timescale 1ns/1ns
module scc_osc_model (
  input  wire logic       extFastStop,
  input  wire logic [3:0] rdyOff,
  output wire logic [3:0] oscIn,
  output wire logic [3:0] oscReady
);
  for (genvar i = 0; i < 4; i++) begin : g_osc
    localparam int H = (i == 0) ? 40 : (i == 1) ? 31 : (i == 2) ? 190 : 170;
    logic lvl = 1'b0;
    // Stopped crystal holds its level
    always #(H) if (!(i == 0 && extFastStop)) lvl = ~lvl;
    assign oscIn[i] = lvl;
  end
  assign oscReady = ~rdyOff;
endmodule

// [test/scc_clock_ctrl_asserts.sv]
// Port-level checks of the clock controller
`timescale 1ns/1ns
`include "scc_defines.svh"
module scc_clock_ctrl_asserts (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic [7:0]        paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [3:0]        oscReady,
  input wire logic              coreClk,
  input wire logic              ccoOut,
  input wire logic              irq,
  input wire scc_pkg::scc_src_e activeSrc,
  input wire logic              switchBusy
);
  import scc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(a, c);
    psel && penable && pready && pwrite && paddr == a && c;
  endsequence
  AST_PREADY_SETUP: assert property (s_setup |=> pready)
    else $error("no access cycle after setup");
  AST_PREADY_ACCESS: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access");
  AST_SLVERR: assert property (pready && paddr > `SCC_ADDR_CCO |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
  AST_SRC_READY: assert property ($changed(activeSrc) |-> (($past(oscReady, 3) >> activeSrc) & 4'h1) != 4'h0)
    else $error("switch to unready source");
  AST_SWITCH_LOW: assert property ($changed(activeSrc) && $past(switchBusy) |-> !coreClk ##1 !coreClk)
    else $error("switch not at low phase");
  AST_CORE_GATE: assert property (s_wr(`SCC_ADDR_GATE, !pwdata[0]) |-> ##3 $stable(coreClk) [*8])
    else $error("core clock runs while gated");
  AST_CCO_LOW: assert property (s_wr(`SCC_ADDR_CCO, pwdata[2:1] == 2'b11) |-> ##2 !ccoOut [*4])
    else $error("clock output not low");
  AST_IRQ_MASK: assert property (s_wr(`SCC_ADDR_IMASK, pwdata[1:0] == 2'b00) |-> ##2 !irq)
    else $error("masked interrupt raised");
  AST_RESET_SRC: assert property ($rose(nrst) |-> activeSrc == SRC_INT_FAST)
    else $error("wrong source after reset");
endmodule
bind scc_clock_ctrl scc_clock_ctrl_asserts u_asserts (.core_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr, .oscReady, .coreClk, .ccoOut, .irq, .activeSrc, .switchBusy);

// [test/tb_scc_clock_ctrl.sv]
// Self-checking bench of the clock controller
`timescale 1ns/1ns
`include "scc_defines.svh"
module tb_scc_clock_ctrl;
  import scc_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wakeup = 1'b0, extFastStop = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  rdyOff = 4'h0, oscIn, oscReady;
  logic        pready, pslverr, coreClk, memClk, rtcClk, lcdClk, ccoOut, irq, switchBusy;
  logic [7:0]  periphClk;
  scc_src_e    activeSrc;
  wire logic [6:0] probes = {lcdClk, periphClk[1:0], ccoOut, rtcClk, memClk, coreClk};
  int          err_count = 0, n_tests = 0;
  scc_clock_ctrl u_dut (.core_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .oscIn, .oscReady, .wakeup, .coreClk, .memClk, .periphClk, .rtcClk, .lcdClk, .ccoOut, .irq, .activeSrc, .switchBusy);
  scc_osc_model u_osc (.extFastStop, .rdyOff, .oscIn, .oscReady);
  always #2 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do @(posedge core_clk); while (pready !== 1'b1 && ++k < 50);
    chk("pready", 32'h1, 32'(pready));
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic cnt(input int s, output int n);
    logic p;
    n = 0;
    @(negedge core_clk);
    p = probes[s];
    repeat (1000) begin
      @(negedge core_clk);
      if (probes[s] !== p) n++;
      p = probes[s];
    end
  endtask
  task automatic wait_src(input scc_src_e s, input int lim);
    int k;
    k = 0;
    do @(negedge core_clk); while ((activeSrc !== s || switchBusy !== 1'b0) && ++k < lim);
    chk("src", 32'(s), 32'(activeSrc));
  endtask
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(`SCC_ADDR_CTRL, r);
    chk("ctrl", 32'h6D, r);
    rd(`SCC_ADDR_GATE, r);
    chk("gate", 32'h7FF, r);
    rd(`SCC_ADDR_CCO, r);
    chk("cco", 32'h0, r);
    chk("src", 32'h1, 32'(activeSrc));
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("slverr", 32'h1, 32'(e));
    chk("errdata", 32'h0, r);
  endtask
  task automatic t_clocks;
    logic [31:0] r;
    int          n;
    wr(`SCC_ADDR_CTRL, 32'h61);
    cnt(0, n);
    chk("div1", 32'h1, 32'(n > 100));
    wr(`SCC_ADDR_CTRL, 32'h6D);
    cnt(0, n);
    chk("div8", 32'h1, 32'(n >= 14 && n <= 18));
    wr(`SCC_ADDR_GATE, 32'h7FE);
    cnt(0, n);
    chk("gated", 32'h1, 32'(n <= 1));
    cnt(1, n);
    chk("mem", 32'h1, 32'(n > 10));
    wr(`SCC_ADDR_GATE, 32'h7FB);
    cnt(4, n);
    chk("per0off", 32'h1, 32'(n <= 1));
    cnt(5, n);
    chk("per1on", 32'h1, 32'(n > 10));
    wr(`SCC_ADDR_GATE, 32'h7FF);
    cnt(6, n);
    chk("lcd", 32'h1, 32'(n > 5));
    wr(`SCC_ADDR_CCO, 32'hA);
    cnt(3, n);
    chk("cco", 32'h1, 32'(n > 100));
    wr(`SCC_ADDR_CCO, 32'h8);
    cnt(3, n);
    chk("ccosys", 32'h1, 32'(n >= 14 && n <= 18));
    wr(`SCC_ADDR_CCO, 32'hD);
    cnt(3, n);
    chk("ccortc", 32'h1, 32'(n >= 20 && n <= 28));
    wr(`SCC_ADDR_CCO, 32'hE);
    cnt(3, n);
    chk("ccolow", 32'h1, 32'(n <= 1));
    wr(`SCC_ADDR_CTRL, 32'h26D);
    cnt(0, n);
    chk("halt", 32'h1, 32'(n <= 1));
    cnt(2, n);
    chk("rtc", 32'h1, 32'(n > 5));
    cnt(6, n);
    chk("lcdhalt", 32'h1, 32'(n <= 1));
    wr(`SCC_ADDR_CTRL, 32'h36D);
    cnt(2, n);
    chk("rtcoff", 32'h1, 32'(n <= 1));
    wr(`SCC_ADDR_CTRL, 32'h16D);
    cnt(0, n);
    chk("waitcore", 32'h1, 32'(n <= 1));
    cnt(1, n);
    chk("waitmem", 32'h1, 32'(n > 10));
    @(posedge core_clk) wakeup <= 1'b1;
    @(posedge core_clk) wakeup <= 1'b0;
    rd(`SCC_ADDR_CTRL, r);
    chk("wake", 32'h0, {30'h0, r[9:8]});
    wr(`SCC_ADDR_CTRL, 32'h2D);
    cnt(2, n);
    chk("rtcsel", 32'h1, 32'(n > 100));
    wr(`SCC_ADDR_CTRL, 32'h6D);
  endtask
  task automatic t_switch;
    scc_src_e    seq [4] = '{SRC_EXT_SLOW, SRC_EXT_FAST, SRC_INT_SLOW, SRC_INT_FAST};
    logic [31:0] r;
    @(posedge core_clk) rdyOff <= 4'h4;
    foreach (seq[i]) begin
      wr(`SCC_ADDR_CTRL, 32'h6C | 32'(seq[i]));
      if (i == 0) begin
        repeat (200) @(negedge core_clk);
        chk("busy", 32'h1, 32'(switchBusy));
        chk("hold", 32'h1, 32'(activeSrc));
        @(posedge core_clk) rdyOff <= 4'h0;
      end
      wait_src(seq[i], 3000);
    end
    rd(`SCC_ADDR_ISTAT, r);
    chk("done", 32'h1, 32'(r[1]));
    wr(`SCC_ADDR_IMASK, 32'h2);
    repeat (2) @(negedge core_clk);
    chk("irq", 32'h1, 32'(irq));
    wr(`SCC_ADDR_ISTAT, 32'h2);
    repeat (2) @(negedge core_clk);
    chk("irqclr", 32'h0, 32'(irq));
  endtask
  task automatic t_monitor;
    logic [31:0] r;
    wr(`SCC_ADDR_IMASK, 32'h1);
    wr(`SCC_ADDR_CTRL, 32'h6C);
    wait_src(SRC_EXT_FAST, 3000);
    @(posedge core_clk) extFastStop <= 1'b1;
    repeat (700) @(negedge core_clk);
    chk("nomon", 32'h0, 32'(activeSrc));
    wr(`SCC_ADDR_CTRL, 32'hEC);
    wait_src(SRC_INT_FAST, 700);
    rd(`SCC_ADDR_CTRL, r);
    chk("ctrlsrc", 32'h1, {30'h0, r[1:0]});
    rd(`SCC_ADDR_ISTAT, r);
    chk("fail", 32'h1, 32'(r[0]));
    chk("irqfail", 32'h1, 32'(irq));
    @(posedge core_clk) extFastStop <= 1'b0;
    wr(`SCC_ADDR_IMASK, 32'h0);
    wr(`SCC_ADDR_ISTAT, 32'h3);
  endtask
  task automatic test_done;
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_clocks();
    t_switch();
    t_monitor();
    test_done();
  end
endmodule
